// ---- design/dcf_pkg.sv ----
// constants shared by the dual-port fifo with mailboxes
// assumes a single system clock; port clocks arrive as sampled pins
`default_nettype none

package dcf_pkg;

    // storage shape
    localparam int DEPTH = 64;
    localparam int WIDTH = 36;
    localparam int BYTES = 4;

    // preset flag offsets picked by the straps
    localparam logic [6:0] OFS_PRESET0 = 7'h10;
    localparam logic [6:0] OFS_PRESET1 = 7'h0C;
    localparam logic [6:0] OFS_PRESET2 = 7'h08;
    localparam logic [6:0] OFS_PRESET3 = 7'h04;

    // cycles after reset release before the straps are taken
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LEVEL = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;

    // control fields and reset value
    localparam int CTRL_PGEN_A = 0;
    localparam int CTRL_PGEN_B = 1;
    localparam int CTRL_ODD = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h4;

    // interrupt status and mask fields
    localparam int IRQ_PAR_A = 0;
    localparam int IRQ_PAR_B = 1;
    localparam int IRQ_MAIL1 = 2;
    localparam int IRQ_MAIL2 = 3;
    localparam int IRQ_W = 4;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

endpackage

`default_nettype wire

// ---- design/dcf_fifo_mailbox.sv ----
// dual-port fifo, port a to port b, with two mailboxes and parity
// assumes port clocks and pins are asynchronous to hclk and sampled;
// software reaches control and status over ahb-lite, zero wait states
//
// What this block does
// - stores 64 words of 36 bits, fifo order
// - transfer on enabled port clock rise
// - both ports may act on one edge
// - full flags synced twice on write clock
// - empty flags synced twice on read clock
// - almost-empty low when count <= offset
// - almost-full low when free <= offset
// - two 36-bit mailboxes, one each direction
// - new-mail flag set on mailbox write
// - passive parity check, transfer never blocked
// - optional parity generation per port
// - 36-bit two-way data bus on each port
// - empty low at reset, rises second read edge
// - full low at reset, rises second write edge
// - offset straps latched at reset release
// - mail select steers to a mailbox
//
// Our own choices: register access over AHB-Lite and the register addresses.
`default_nettype none

module dcf_fifo_mailbox #(
    parameter int DEPTH = dcf_pkg::DEPTH,
    parameter logic [6:0] OFS0 = dcf_pkg::OFS_PRESET0,
    parameter logic [6:0] OFS1 = dcf_pkg::OFS_PRESET1,
    parameter logic [6:0] OFS2 = dcf_pkg::OFS_PRESET2,
    parameter logic [6:0] OFS3 = dcf_pkg::OFS_PRESET3
) (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output var logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // interrupt
    output logic irq,
    // flag offset straps
    input wire logic [1:0] offset_select,
    // port a, the writing side
    input wire logic write_port_clock,
    input wire logic write_side_select_n,
    input wire logic write_side_enable,
    input wire logic write_side_write,
    input wire logic write_side_mail_select,
    input wire logic [35:0] write_side_data_in,
    output var logic [35:0] write_side_data_out,
    output logic write_side_data_oe,
    output var logic full_flag_n,
    output var logic almost_full_n,
    output logic write_side_mail_waiting_n,
    output logic write_side_parity_err_n,
    // port b, the reading side
    input wire logic read_port_clock,
    input wire logic read_side_select_n,
    input wire logic read_side_enable,
    input wire logic read_side_write,
    input wire logic read_side_mail_select,
    input wire logic [35:0] read_side_data_in,
    output var logic [35:0] read_side_data_out,
    output logic read_side_data_oe,
    output var logic empty_flag_n,
    output var logic almost_empty_n,
    output logic read_side_mail_waiting_n,
    output logic read_side_parity_err_n
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int WD = dcf_pkg::WIDTH;
    localparam int PW = WD + 5;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    // binary to gray
    function automatic logic [CW-1:0] to_gray(input logic [CW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // gray to binary
    function automatic logic [CW-1:0] from_gray(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        for (int i = 0; i < CW; i++)
        begin
            b[i] = ^(g >> i);
        end
        return b;
    endfunction

    // put a parity bit above each byte
    function automatic logic [WD-1:0] par_gen(input logic [WD-1:0] w,
                                              input logic odd);
        logic [WD-1:0] r;
        r = w;
        for (int i = 0; i < dcf_pkg::BYTES; i++)
        begin
            r[9*i+8] = (^w[9*i +: 8]) ^ odd;
        end
        return r;
    endfunction

    // high when any byte fails its parity
    function automatic logic par_bad(input logic [WD-1:0] w,
                                     input logic odd);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < dcf_pkg::BYTES; i++)
        begin
            bad = bad | ((^w[9*i +: 9]) != odd);
        end
        return bad;
    endfunction

    // pin synchronisers, two stages per port
    logic [PW-1:0] a_s1_r, a_s2_r, b_s1_r, b_s2_r;
    logic a_clk_prev_r, b_clk_prev_r;
    logic [1:0] ofs_s1_r, ofs_s2_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_s1_r <= '0;
            a_s2_r <= '0;
            b_s1_r <= '0;
            b_s2_r <= '0;
            a_clk_prev_r <= 1'b0;
            b_clk_prev_r <= 1'b0;
            ofs_s1_r <= 2'h0;
            ofs_s2_r <= 2'h0;
        end
        else if (ce)
        begin
            a_s1_r <= {write_port_clock, write_side_select_n,
                       write_side_enable, write_side_write,
                       write_side_mail_select, write_side_data_in};
            a_s2_r <= a_s1_r;
            b_s1_r <= {read_port_clock, read_side_select_n,
                       read_side_enable, read_side_write,
                       read_side_mail_select, read_side_data_in};
            b_s2_r <= b_s1_r;
            a_clk_prev_r <= a_s2_r[PW-1];
            b_clk_prev_r <= b_s2_r[PW-1];
            ofs_s1_r <= offset_select;
            ofs_s2_r <= ofs_s1_r;
        end
    end

    // port decode from the second sync stage
    logic a_edge, a_act, a_wr, a_mail, b_edge, b_act, b_wr, b_mail;
    logic [WD-1:0] a_din, b_din, b_src;
    logic a_fifo_wr, a_mail_wr, a_mail_rd, b_fifo_rd, b_mail_wr, b_mail_rd;

    assign a_edge = ce & a_s2_r[PW-1] & ~a_clk_prev_r;
    assign b_edge = ce & b_s2_r[PW-1] & ~b_clk_prev_r;
    assign a_act = a_edge & ~a_s2_r[PW-2] & a_s2_r[PW-3];
    assign b_act = b_edge & ~b_s2_r[PW-2] & b_s2_r[PW-3];
    assign a_wr = a_s2_r[PW-4];
    assign b_wr = b_s2_r[PW-4];
    assign a_mail = a_s2_r[PW-5];
    assign b_mail = b_s2_r[PW-5];
    assign a_din = a_s2_r[WD-1:0];
    assign b_din = b_s2_r[WD-1:0];
    // mail select steers to a mailbox; flags block the memory
    assign a_fifo_wr = a_act & a_wr & ~a_mail & full_flag_n;
    assign a_mail_wr = a_act & a_wr & a_mail;
    assign a_mail_rd = a_act & ~a_wr & a_mail;
    assign b_fifo_rd = b_act & ~b_wr & ~b_mail & empty_flag_n;
    assign b_mail_wr = b_act & b_wr & b_mail;
    assign b_mail_rd = b_act & ~b_wr & b_mail;

    // offset register loaded once from the straps
    logic [1:0] strap_cnt_r;
    logic [6:0] offset_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            strap_cnt_r <= 2'h0;
            offset_r <= 7'h00;
        end
        else if (ce && strap_cnt_r != 2'h3)
        begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == dcf_pkg::STRAP_WAIT)
            begin
                case (ofs_s2_r)
                    2'h0: offset_r <= OFS0;
                    2'h1: offset_r <= OFS1;
                    2'h2: offset_r <= OFS2;
                    default: offset_r <= OFS3;
                endcase
            end
        end
    end

    // storage, written at the write pointer
    logic [WD-1:0] mem_r [DEPTH];
    logic [CW-1:0] wptr_r, wgray_r, rptr_r, rgray_r;
    logic [CW-1:0] rgray_s1_r, wgray_s1_r;

    always_ff @(posedge hclk)
    begin
        if (a_fifo_wr)
        begin
            mem_r[wptr_r[AW-1:0]] <= a_din;
        end
    end

    // write side: pointer, read pointer stage, full flags
    logic [CW-1:0] wptr_nxt, wcnt_nxt, wcnt;
    logic [1:0] a_up_r;

    assign wptr_nxt = a_fifo_wr ? wptr_r + CW'(1) : wptr_r;
    assign wcnt_nxt = wptr_nxt - from_gray(rgray_s1_r);
    assign wcnt = wptr_r - from_gray(rgray_s1_r);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wptr_r <= '0;
            wgray_r <= '0;
            rgray_s1_r <= '0;
            a_up_r <= 2'h0;
            full_flag_n <= 1'b0;
            almost_full_n <= 1'b0;
        end
        else if (a_edge)
        begin
            wptr_r <= wptr_nxt;
            wgray_r <= to_gray(wptr_nxt);
            rgray_s1_r <= rgray_r;
            a_up_r <= {a_up_r[0], 1'b1};
            full_flag_n <= a_up_r[0] & (wcnt_nxt < DEPTH_C);
            almost_full_n <= a_up_r[0]
                             & ((DEPTH_C - wcnt_nxt) > offset_r);
        end
    end

    // read side: pointer, write pointer stage, empty flags
    logic [CW-1:0] rptr_nxt, rcnt_nxt, rcnt;
    logic [WD-1:0] fifo_q_r;

    assign rptr_nxt = b_fifo_rd ? rptr_r + CW'(1) : rptr_r;
    assign rcnt_nxt = from_gray(wgray_s1_r) - rptr_nxt;
    assign rcnt = from_gray(wgray_s1_r) - rptr_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rptr_r <= '0;
            rgray_r <= '0;
            wgray_s1_r <= '0;
            empty_flag_n <= 1'b0;
            almost_empty_n <= 1'b0;
        end
        else if (b_edge)
        begin
            rptr_r <= rptr_nxt;
            rgray_r <= to_gray(rptr_nxt);
            wgray_s1_r <= wgray_r;
            empty_flag_n <= (rcnt_nxt != '0);
            almost_empty_n <= (rcnt_nxt > offset_r);
        end
    end

    // fifo output register, loaded by each read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fifo_q_r <= '0;
        end
        else if (b_fifo_rd)
        begin
            fifo_q_r <= mem_r[rptr_r[AW-1:0]];
        end
    end

    // mailboxes: mail1 carries a to b, mail2 carries b to a
    logic [WD-1:0] mail1_r, mail2_r;
    logic mail1_new_r, mail2_new_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mail1_r <= '0;
            mail2_r <= '0;
            mail1_new_r <= 1'b0;
            mail2_new_r <= 1'b0;
        end
        else if (ce)
        begin
            if (a_mail_wr)
            begin
                mail1_r <= a_din;
            end
            if (b_mail_wr)
            begin
                mail2_r <= b_din;
            end
            // a new write outranks a read in the same cycle
            mail1_new_r <= a_mail_wr | (mail1_new_r & ~b_mail_rd);
            mail2_new_r <= b_mail_wr | (mail2_new_r & ~a_mail_rd);
        end
    end

    assign read_side_mail_waiting_n = ~mail1_new_r;
    assign write_side_mail_waiting_n = ~mail2_new_r;

    // software registers
    logic [dcf_pkg::CTRL_W-1:0] ctrl_r;
    logic [dcf_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_event, irq_clr;
    logic a_perr_r, b_perr_r;
    logic ap_valid_r, ap_write_r;
    logic [7:0] ap_addr_r;
    logic odd;

    assign odd = ctrl_r[dcf_pkg::CTRL_ODD];

    // passive parity check on words written at a port
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_perr_r <= 1'b0;
            b_perr_r <= 1'b0;
        end
        else if (ce)
        begin
            if (a_act && a_wr)
            begin
                a_perr_r <= par_bad(a_din, odd);
            end
            if (b_act && b_wr)
            begin
                b_perr_r <= par_bad(b_din, odd);
            end
        end
    end

    assign write_side_parity_err_n = ~a_perr_r;
    assign read_side_parity_err_n = ~b_perr_r;

    // port b shows mail1 on mail select, else the fifo word
    assign b_src = b_mail ? mail1_r : fifo_q_r;

    // port data outputs, with optional parity generation
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            write_side_data_out <= '0;
            read_side_data_out <= '0;
        end
        else if (ce)
        begin
            if (a_mail_rd)
            begin
                write_side_data_out <= ctrl_r[dcf_pkg::CTRL_PGEN_A]
                    ? par_gen(mail2_r, odd) : mail2_r;
            end
            read_side_data_out <= ctrl_r[dcf_pkg::CTRL_PGEN_B]
                ? par_gen(b_src, odd) : b_src;
        end
    end

    // drive a bus while its port is read
    assign write_side_data_oe = ~a_s2_r[PW-2] & ~a_wr;
    assign read_side_data_oe = ~b_s2_r[PW-2] & ~b_wr;

    // interrupt events
    assign irq_event[dcf_pkg::IRQ_PAR_A] = a_act & a_wr & par_bad(a_din, odd);
    assign irq_event[dcf_pkg::IRQ_PAR_B] = b_act & b_wr & par_bad(b_din, odd);
    assign irq_event[dcf_pkg::IRQ_MAIL1] = a_mail_wr;
    assign irq_event[dcf_pkg::IRQ_MAIL2] = b_mail_wr;

    // ahb-lite address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r <= 8'h00;
        end
        else if (ce && hready)
        begin
            ap_valid_r <= hsel & htrans[1] & (hsize == 3'h2);
            ap_write_r <= hwrite;
            ap_addr_r <= haddr[7:0];
        end
    end

    // register writes in the data phase; status bits clear on a one
    logic dp_wr;
    assign dp_wr = ce & ap_valid_r & ap_write_r;
    assign irq_clr = (dp_wr && ap_addr_r == dcf_pkg::REG_IRQ_STAT)
                     ? hwdata[dcf_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r <= dcf_pkg::CTRL_RST;
            irq_mask_r <= dcf_pkg::IRQ_MASK_RST;
            irq_stat_r <= '0;
        end
        else if (ce)
        begin
            if (dp_wr && ap_addr_r == dcf_pkg::REG_CTRL)
            begin
                ctrl_r <= hwdata[dcf_pkg::CTRL_W-1:0];
            end
            if (dp_wr && ap_addr_r == dcf_pkg::REG_IRQ_MASK)
            begin
                irq_mask_r <= hwdata[dcf_pkg::IRQ_W-1:0];
            end
            irq_stat_r <= irq_event | (irq_stat_r & ~irq_clr); // set wins
        end
    end

    // read data taken at address phase, valid in data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0;
        end
        else if (ce && hready)
        begin
            case (haddr[7:0])
                dcf_pkg::REG_CTRL:
                    hrdata <= {29'h0, ctrl_r};
                dcf_pkg::REG_STATUS:
                    hrdata <= {17'h0, offset_r,
                               b_perr_r, a_perr_r, mail2_new_r,
                               mail1_new_r, almost_empty_n, empty_flag_n,
                               almost_full_n, full_flag_n};
                dcf_pkg::REG_LEVEL:
                    hrdata <= {9'h0, rcnt, 9'h0, wcnt};
                dcf_pkg::REG_IRQ_STAT:
                    hrdata <= {28'h0, irq_stat_r};
                dcf_pkg::REG_IRQ_MASK:
                    hrdata <= {28'h0, irq_mask_r};
                default:
                    hrdata <= 32'h0;
            endcase
        end
    end

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(irq_stat_r & irq_mask_r);

endmodule

`default_nettype wire

// ---- design/dcf_pkg_dummy_unused.sv ----
`default_nettype none
`default_nettype wire

// ---- test/dcf_fifo_mailbox_properties.sv ----
// assertions on fifo flags, mail flags and port-a read data
// assumes port clock pins are slow and sampled by hclk
`default_nettype none

module dcf_fifo_mailbox_properties (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // port clocks
    input wire logic write_port_clock,
    input wire logic read_port_clock,
    // flags
    input wire logic full_flag_n,
    input wire logic almost_full_n,
    input wire logic empty_flag_n,
    input wire logic almost_empty_n,
    input wire logic write_side_mail_waiting_n,
    input wire logic read_side_mail_waiting_n,
    // port a data
    input wire logic [35:0] write_side_data_out
);
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // port clock high now or one cycle ago
    sequence s_a_high;
        write_port_clock || $past(write_port_clock);
    endsequence
    sequence s_b_high;
        read_port_clock || $past(read_port_clock);
    endsequence

    // flags move only on their own port clock
    property p_empty_edge;
        $changed(empty_flag_n) |-> s_b_high;
    endproperty
    property p_full_edge;
        $changed(full_flag_n) |-> s_a_high;
    endproperty
    property p_afull_edge;
        $changed(almost_full_n) |-> s_a_high;
    endproperty
    property p_aempty_edge;
        $changed(almost_empty_n) |-> s_b_high;
    endproperty
    // empty or full implies almost flag low
    property p_empty_in_ae;
        $fell(empty_flag_n) |-> !almost_empty_n;
    endproperty
    property p_full_in_af;
        $fell(full_flag_n) |-> !almost_full_n;
    endproperty
    // new mail only from a writing port edge; port a data changes only on a port a edge
    property p_mail1_set;
        $fell(read_side_mail_waiting_n) |-> s_a_high;
    endproperty
    property p_mail2_set;
        $fell(write_side_mail_waiting_n) |-> s_b_high;
    endproperty
    property p_a_data;
        $changed(write_side_data_out) |-> s_a_high;
    endproperty

    a_empty_edge: assert property (p_empty_edge)
        else $error("empty off b edge");
    a_full_edge: assert property (p_full_edge)
        else $error("full off a edge");
    a_afull_edge: assert property (p_afull_edge)
        else $error("almost full off a edge");
    a_aempty_edge: assert property (p_aempty_edge)
        else $error("almost empty off b edge");
    a_empty_in_ae: assert property (p_empty_in_ae)
        else $error("empty without almost empty");
    a_full_in_af: assert property (p_full_in_af)
        else $error("full without almost full");
    a_mail1_set: assert property (p_mail1_set)
        else $error("mail1 set off a edge");
    a_mail2_set: assert property (p_mail2_set)
        else $error("mail2 set off b edge");
    a_a_data: assert property (p_a_data)
        else $error("a data off a edge");
endmodule

`default_nettype wire

// ---- test/dcf_port_host.sv ----
// host model driving both fifo ports on shared port clocks
// assumes hclk paces it and the block samples the port pins
`default_nettype none

module dcf_port_host (
    // pacing clock
    input wire logic hclk,
    // pins to the block, bit 0 port a, bit 1 port b
    output logic [1:0] pclk,
    output logic [1:0] sel_n,
    output logic [1:0] en,
    output logic [1:0] wr,
    output logic [1:0] mb,
    output logic [1:0] offset_select,
    // resolved data buses
    output logic [35:0] bus_a,
    output logic [35:0] bus_b,
    // block data outputs
    input wire logic [35:0] dout_a,
    input wire logic [35:0] dout_b,
    input wire logic oe_a,
    input wire logic oe_b
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] drv;
    logic [35:0] val_a;
    logic [35:0] val_b;

    // a released bus shows the inverse of its last value
    assign bus_a = oe_a ? dout_a : (drv[0] ? val_a : ~val_a);
    assign bus_b = oe_b ? dout_b : (drv[1] ? val_b : ~val_b);

    // idle pins; straps never move
    initial
    begin
        pclk = 2'h0;
        sel_n = 2'h3;
        en = 2'h0;
        wr = 2'h0;
        mb = 2'h0;
        drv = 2'h0;
        val_a = 36'h0;
        val_b = 36'h0;
        offset_select = 2'h0;
    end

    // one cycle on both port clocks; act enables each side
    task automatic op(input logic [1:0] act, input logic [1:0] w,
        input logic [1:0] m, input logic [35:0] da, input logic [35:0] db,
        output logic [35:0] qa, output logic [35:0] qb);
        sel_n <= ~act;
        en <= act;
        wr <= w;
        mb <= m;
        drv <= act & w;
        if (act[0] && w[0])
            val_a <= da;
        if (act[1] && w[1])
            val_b <= db;
        repeat (4) @(posedge hclk);
        pclk <= 2'h3;
        repeat (6) @(posedge hclk);
        qa = bus_a;
        qb = bus_b;
        pclk <= 2'h0;
        sel_n <= 2'h3;
        en <= 2'h0;
        drv <= 2'h0;
        repeat (4) @(posedge hclk);
    endtask
endmodule

`default_nettype wire

// ---- test/dcf_fifo_mailbox_test.sv ----
// self-checking bench for the fifo with mailboxes
// assumes the host model paces ports; hready is the slave hreadyout
`default_nettype none

module dcf_fifo_mailbox_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [1:0] pclk, sel_n, en, wr, mb, ofs;
    logic [35:0] bus_a, bus_b, dout_a, dout_b, qa, qb, bad;
    logic oe_a, oe_b, full_flag_n, almost_full_n, empty_flag_n;
    logic almost_empty_n, wmw_n, rmw_n, wpe_n, rpe_n;
    int n_fail = 0;
    int total_checks = 0;
    int i;

    // 250 MHz system clock
    always #2 hclk = ~hclk;

    dcf_fifo_mailbox dut (
        .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .irq, .offset_select(ofs), .write_port_clock(pclk[0]),
        .write_side_select_n(sel_n[0]), .write_side_enable(en[0]),
        .write_side_write(wr[0]), .write_side_mail_select(mb[0]),
        .write_side_data_in(bus_a), .write_side_data_out(dout_a),
        .write_side_data_oe(oe_a), .full_flag_n, .almost_full_n,
        .write_side_mail_waiting_n(wmw_n), .write_side_parity_err_n(wpe_n),
        .read_port_clock(pclk[1]), .read_side_select_n(sel_n[1]),
        .read_side_enable(en[1]), .read_side_write(wr[1]),
        .read_side_mail_select(mb[1]), .read_side_data_in(bus_b),
        .read_side_data_out(dout_b), .read_side_data_oe(oe_b),
        .empty_flag_n, .almost_empty_n, .read_side_mail_waiting_n(rmw_n),
        .read_side_parity_err_n(rpe_n));

    dcf_port_host u_host (
        .hclk, .pclk, .sel_n, .en, .wr, .mb, .offset_select(ofs), .bus_a,
        .bus_b, .dout_a, .dout_b, .oe_a, .oe_b);

    // word with odd parity in each nine-bit lane
    function automatic logic [35:0] word(input int n);
        logic [31:0] v;
        logic [35:0] w;
        v = {n[7:0] ^ 8'hA5, ~n[7:0], n[7:0], 8'h3C};
        for (int k = 0; k < 4; k++)
            w[k * 9 +: 9] = {~^v[k * 8 +: 8], v[k * 8 +: 8]};
        return w;
    endfunction

    // compare and count
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic cb(input logic g, input logic e);
        chk({35'h0, g}, {35'h0, e});
    endtask

    // one ahb-lite single word transfer
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0, r);
        chk({4'h0, r}, {4'h0, e});
    endtask

    // write, then an edge for irq to settle
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, r);
        @(posedge hclk);
    endtask

    task automatic idle(input int n);
        repeat (n) u_host.op(2'h0, 2'h0, 2'h0, 36'h0, 36'h0, qa, qb);
    endtask

    task automatic end_sim;
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (5) @(posedge hclk);
        chk({25'h0, full_flag_n, almost_full_n, empty_flag_n, almost_empty_n,
            wmw_n, rmw_n, wpe_n, rpe_n, irq, hreadyout, hresp},
            36'h7A);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(dcf_pkg::REG_CTRL, {29'h0, dcf_pkg::CTRL_RST});
        rd(dcf_pkg::REG_IRQ_MASK, {28'h0, dcf_pkg::IRQ_MASK_RST});
        rd(8'h20, 32'h0);
        ahb(1'b0, dcf_pkg::REG_STATUS, 32'h0, r);
        chk({29'h0, r[14:8]}, {29'h0, dcf_pkg::OFS_PRESET0});
        idle(1);
        cb(full_flag_n, 1'b0);
        idle(1);
        cb(full_flag_n, 1'b1);
        // fill past full; the extra write is refused
        for (i = 0; i < 65; i++)
        begin
            u_host.op(2'h1, 2'h1, 2'h0, word(i), 36'h0, qa, qb);
            if (i == 0)
            begin
                cb(empty_flag_n, 1'b0);
                idle(1);
                cb(empty_flag_n, 1'b0);
                idle(1);
                cb(empty_flag_n, 1'b1);
            end
            if (i == 46 || i == 47)
            begin
                idle(2);
                cb(almost_full_n, i != 47);
            end
        end
        idle(2);
        cb(full_flag_n, 1'b0);
        cb(almost_empty_n, 1'b1);
        // drain past empty; the extra read is refused
        for (i = 0; i < 65; i++)
        begin
            u_host.op(2'h2, 2'h0, 2'h0, 36'h0, 36'h0, qa, qb);
            chk(qb, word(i < 64 ? i : 63));
            if (i == 46 || i == 47)
            begin
                idle(2);
                cb(almost_empty_n, i != 47);
            end
        end
        cb(empty_flag_n, 1'b0);
        idle(2);
        cb(almost_full_n, 1'b1);
        // both mailboxes written and read on shared edges
        u_host.op(2'h3, 2'h3, 2'h3, word(5), word(9), qa, qb);
        cb(rmw_n, 1'b0);
        cb(wmw_n, 1'b0);
        u_host.op(2'h3, 2'h0, 2'h3, 36'h0, 36'h0, qa, qb);
        chk(qa, word(9));
        chk(qb, word(5));
        cb(rmw_n, 1'b1);
        cb(wmw_n, 1'b1);
        rd(dcf_pkg::REG_IRQ_STAT, 32'hC);
        wr_reg(dcf_pkg::REG_IRQ_STAT, 32'hF);
        // bad parity still lands; interrupt masked, unmasked, cleared
        bad = word(3) ^ 36'h8_0000_0000;
        u_host.op(2'h1, 2'h1, 2'h1, bad, 36'h0, qa, qb);
        cb(wpe_n, 1'b0);
        rd(dcf_pkg::REG_IRQ_STAT, 32'h5);
        cb(irq, 1'b0);
        wr_reg(dcf_pkg::REG_IRQ_MASK, 32'h1);
        cb(irq, 1'b1);
        wr_reg(dcf_pkg::REG_IRQ_STAT, 32'h5);
        cb(irq, 1'b0);
        u_host.op(2'h2, 2'h0, 2'h2, 36'h0, 36'h0, qa, qb);
        chk(qb, bad);
        // port b parity generation repairs the lane on read
        wr_reg(dcf_pkg::REG_CTRL, 32'h6);
        u_host.op(2'h1, 2'h1, 2'h1, bad, 36'h0, qa, qb);
        u_host.op(2'h2, 2'h0, 2'h2, 36'h0, 36'h0, qa, qb);
        chk(qb, word(3));
        end_sim;
    end

    // watchdog
    initial
    begin
        #100000;
        n_fail++;
        end_sim;
    end
endmodule

bind dcf_fifo_mailbox dcf_fifo_mailbox_properties u_props (
    .hclk, .hresetn, .write_port_clock, .read_port_clock, .full_flag_n,
    .almost_full_n, .empty_flag_n, .almost_empty_n,
    .write_side_mail_waiting_n, .read_side_mail_waiting_n,
    .write_side_data_out);

`default_nettype wire
